// *** core/rsf_encoder.v ***
// RS(130,k) encoder with round-robin interleaving, symbol FIFO and scrambler
`timescale 1ns/1ps
`include "rsf_regs.vh"
// Function
// - Depth one means no interleaving; superframe equals one encoded frame.
// - Master direction always uses depth one.
// - Slave depth per speed: 1 at 2.5G, 2 at 5G, 4 at 10G.
// - Slave gathers L frames into 122*L message symbols, highest index first.
// - With depth above one, symbols go round-robin to L encoders.
// - Slave output: all messages, then parities by position high-low, encoders 1..L.
// - Codeword of 130 byte symbols; k is 124 master, 122 slave.
// - Field uses x^8+x^4+x^3+x^2+1; generator roots alpha^(129-k) down to 1.
// - Generator coefficients from table, master seven, slave nine.
// - Master vector: blocks in 974:0, maintenance bits in 991:975.
// - Slave vector: blocks in 974:0, one maintenance bit at 975.
// - Highest symbol fed first; bit zero of each symbol sent first.
// - Parity is LFSR remainder, cleared before each message.
// - Codeword sent from degree 129 down to parity zero.
// - Master scrambler uses 1 + x^13 + x^33.

module rsf_fifo #(
    parameter W = 8,
    parameter D = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_b,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_r [0:D-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;
    assign in_ready = (cnt_r != D[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= (wr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

module rsf_encoder (
    // Clock and reset
    input wire clk_sys,
    input wire rst_b,
    // Configuration
    input wire master_mode,
    input wire [1:0] speed_sel,
    input wire data_mode,
    // Frame input from block grouping
    input wire frame_valid,
    output wire frame_ready,
    input wire [`RSF_BLK_W-1:0] grouped_block_vector,
    input wire [`RSF_MAINT_W-1:0] maintenance_bits,
    // Training source
    input wire [1:0] training_bits,
    // Bit pair output to symbol mapper
    output wire pair_valid,
    input wire pair_ready,
    output wire [1:0] pair_bits
);
    // Multiply in GF(2^8)
    function [7:0] gf_mul;
        input [7:0] a;
        input [7:0] b;
        reg [7:0] acc;
        reg [7:0] sh;
        integer i;
        begin
            acc = 8'h00;
            sh = a;
            for (i = 0; i < 8; i = i + 1) begin
                if (b[i]) begin
                    acc = acc ^ sh;
                end
                sh = sh[7] ? ({sh[6:0], 1'b0} ^ `RSF_PRIM_LOW) : {sh[6:0], 1'b0};
            end
            gf_mul = acc;
        end
    endfunction
    // Generator coefficient g_i, hex values of the table
    function [7:0] gen_coef;
        input slave;
        input [2:0] idx;
        begin
            case ({slave, idx})
                4'h0: gen_coef = 8'h26;
                4'h1: gen_coef = 8'hE3;
                4'h2: gen_coef = 8'h20;
                4'h3: gen_coef = 8'hDA;
                4'h4: gen_coef = 8'h01;
                4'h5: gen_coef = 8'h3F;
                4'h8: gen_coef = 8'h18;
                4'h9: gen_coef = 8'hC8;
                4'hA: gen_coef = 8'hAD;
                4'hB: gen_coef = 8'hEF;
                4'hC: gen_coef = 8'h36;
                4'hD: gen_coef = 8'h51;
                4'hE: gen_coef = 8'h0B;
                4'hF: gen_coef = 8'hFF;
                default: gen_coef = 8'h00;
            endcase
        end
    endfunction
    // One step of the side-stream scrambler
    function [`RSF_SCR_W-1:0] scr_step;
        input [`RSF_SCR_W-1:0] s;
        begin
            scr_step = {s[`RSF_SCR_W-2:0], s[`RSF_SCR_TAP_A] ^ s[`RSF_SCR_TAP_B]};
        end
    endfunction
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg frame_ready_r;
    reg [`RSF_MSG_W-1:0] msg_r;
    reg [255:0] par_r;
    reg [255:0] par_nxt;
    reg slave_r;
    reg [1:0] lm1_r;
    reg [1:0] frame_cnt_r;
    reg [1:0] enc_r;
    reg [6:0] sym_cnt_r;
    reg [2:0] pos_r;
    reg [7:0] fb;
    reg [7:0] push_sym;
    reg push_en;
    reg [1:0] lm1_cfg;
    integer r;
    wire [6:0] k_sym;
    wire [3:0] np_sym;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_pop;
    wire [7:0] fifo_out_data;
    wire take_frame;
    wire step;
    wire [`RSF_SCR_W-1:0] scr_s1;
    wire [`RSF_SCR_W-1:0] scr_s2;
    reg [`RSF_SCR_W-1:0] scr_r;
    reg [1:0] nib_r;
    reg [1:0] pair_r;
    reg pair_valid_r;
    wire pair_free;
    wire [1:0] data_pair;
    assign k_sym = slave_r ? `RSF_K_SLAVE : `RSF_K_MASTER;
    assign np_sym = slave_r ? `RSF_NP_SLAVE : `RSF_NP_MASTER;
    assign take_frame = frame_valid && frame_ready_r;
    assign frame_ready = frame_ready_r;
    // Depth chosen from direction and speed
    always @* begin
        lm1_cfg = `RSF_LM1_D1;
        if (!master_mode) begin
            case (speed_sel)
                `RSF_SPD_5G: lm1_cfg = `RSF_LM1_D2;
                `RSF_SPD_10G: lm1_cfg = `RSF_LM1_D4;
                default: lm1_cfg = `RSF_LM1_D1;
            endcase
        end
    end

    // LFSR division of the selected encoder, and FIFO feed
    always @* begin
        par_nxt = par_r;
        push_en = 1'b0;
        push_sym = 8'h00;
        fb = msg_r[7:0] ^ par_r[{enc_r, 6'h00} + {np_sym[2:0] - 3'h1, 3'h0} +: 8];
        if (state_r == `RSF_ST_MSG) begin
            push_en = 1'b1;
            push_sym = msg_r[7:0];
            for (r = 7; r >= 0; r = r - 1) begin
                if (r < np_sym) begin
                    par_nxt[{enc_r, 6'h00} + r * 8 +: 8] =
                        ((r == 0) ? 8'h00 : par_r[{enc_r, 6'h00} + (r - 1) * 8 +: 8])
                        ^ gf_mul(fb, gen_coef(slave_r, r[2:0]));
                end
            end
        end else if (state_r == `RSF_ST_PAR) begin
            push_en = 1'b1;
            push_sym = par_r[{enc_r, 6'h00} + {pos_r, 3'h0} +: 8];
        end
    end

    assign step = push_en && fifo_in_ready;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            `RSF_ST_LOAD: begin
                if (take_frame) begin
                    state_nxt = `RSF_ST_MSG;
                end
            end
            `RSF_ST_MSG: begin
                if (step && sym_cnt_r == k_sym - 7'h01) begin
                    state_nxt = (frame_cnt_r == lm1_r) ? `RSF_ST_PAR : `RSF_ST_LOAD;
                end
            end
            `RSF_ST_PAR: begin
                if (step && pos_r == 3'h0 && enc_r == lm1_r) begin
                    state_nxt = `RSF_ST_LOAD;
                end
            end
            default: state_nxt = `RSF_ST_LOAD;
        endcase
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= `RSF_ST_LOAD;
            frame_ready_r <= 1'b0;
            msg_r <= {`RSF_MSG_W{1'b0}};
            par_r <= 256'h0;
            slave_r <= 1'b0;
            lm1_r <= `RSF_LM1_D1;
            frame_cnt_r <= 2'h0;
            enc_r <= 2'h0;
            sym_cnt_r <= 7'h00;
            pos_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            frame_ready_r <= (state_nxt == `RSF_ST_LOAD) && !take_frame;
            if (take_frame) begin
                sym_cnt_r <= 7'h00;
                if ((frame_cnt_r == 2'h0) ? master_mode : !slave_r) begin
                    msg_r <= {maintenance_bits, grouped_block_vector};
                end else begin
                    msg_r <= {16'h0000, maintenance_bits[0], grouped_block_vector};
                end
                if (frame_cnt_r == 2'h0) begin
                    slave_r <= !master_mode;
                    lm1_r <= lm1_cfg;
                    enc_r <= 2'h0;
                    par_r <= 256'h0;
                end
            end else if (state_r == `RSF_ST_MSG && step) begin
                par_r <= par_nxt;
                msg_r <= {8'h00, msg_r[`RSF_MSG_W-1:8]};
                sym_cnt_r <= sym_cnt_r + 7'h01;
                enc_r <= (enc_r == lm1_r) ? 2'h0 : enc_r + 2'h1;
                if (sym_cnt_r == k_sym - 7'h01) begin
                    if (frame_cnt_r == lm1_r) begin
                        frame_cnt_r <= 2'h0;
                        enc_r <= 2'h0;
                        pos_r <= np_sym[2:0] - 3'h1;
                    end else begin
                        frame_cnt_r <= frame_cnt_r + 2'h1;
                    end
                end
            end else if (state_r == `RSF_ST_PAR && step) begin
                if (enc_r == lm1_r) begin
                    enc_r <= 2'h0;
                    pos_r <= pos_r - 3'h1;
                end else begin
                    enc_r <= enc_r + 2'h1;
                end
            end
        end
    end

    rsf_fifo #(
        .W(`RSF_FIFO_W),
        .D(`RSF_FIFO_D),
        .AW(`RSF_FIFO_AW)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(push_en),
        .in_ready(fifo_in_ready),
        .in_data(push_sym),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Pair serializer, bit zero of each symbol first
    assign scr_s1 = scr_step(scr_r);
    assign scr_s2 = scr_step(scr_s1);
    assign pair_free = !pair_valid_r || pair_ready;
    assign data_pair = fifo_out_data[{nib_r, 1'b0} +: 2];
    assign fifo_pop = data_mode && pair_free && fifo_out_valid && (nib_r == 2'h3);
    assign pair_valid = pair_valid_r;
    assign pair_bits = pair_r;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            scr_r <= `RSF_SCR_SEED;
            nib_r <= 2'h0;
            pair_r <= 2'h0;
            pair_valid_r <= 1'b0;
        end else if (pair_free) begin
            if (!data_mode) begin
                pair_r <= {scr_s2[0] ^ training_bits[1], scr_s1[0] ^ training_bits[0]};
                pair_valid_r <= 1'b1;
                scr_r <= scr_s2;
            end else if (fifo_out_valid) begin
                pair_r <= {scr_s2[0] ^ data_pair[1], scr_s1[0] ^ data_pair[0]};
                pair_valid_r <= 1'b1;
                scr_r <= scr_s2;
                nib_r <= nib_r + 2'h1;
            end else begin
                pair_valid_r <= 1'b0;
            end
        end
    end
endmodule

// *** pkg/rsf_regs.vh ***
// Constants for the RS-FEC encoder, interleaver and output scrambler
`ifndef RSF_REGS_VH
`define RSF_REGS_VH
// Codeword and message sizes in symbols
`define RSF_N_SYM 8'h82
`define RSF_K_MASTER 7'h7C
`define RSF_K_SLAVE 7'h7A
// Parity symbols per codeword, 130-k
`define RSF_NP_MASTER 4'h6
`define RSF_NP_SLAVE 4'h8
// Low eight bits of x^8+x^4+x^3+x^2+1
`define RSF_PRIM_LOW 8'h1D
// Message vector layout
`define RSF_BLK_W 975
`define RSF_MAINT_W 17
`define RSF_MSG_W 992
// Speed select codes, slave side
`define RSF_SPD_2G5 2'h0
`define RSF_SPD_5G 2'h1
`define RSF_SPD_10G 2'h2
// Interleaving depth minus one
`define RSF_LM1_D1 2'h0
`define RSF_LM1_D2 2'h1
`define RSF_LM1_D4 2'h3
// Encoder states
`define RSF_ST_LOAD 2'h0
`define RSF_ST_MSG 2'h1
`define RSF_ST_PAR 2'h2
// Side-stream scrambler taps of 1 + x^13 + x^33, and nonzero seed
`define RSF_SCR_W 33
`define RSF_SCR_TAP_A 32
`define RSF_SCR_TAP_B 12
`define RSF_SCR_SEED 33'h1FFFFFFFF
// Output FIFO shape
`define RSF_FIFO_W 8
`define RSF_FIFO_D 8
`define RSF_FIFO_AW 3
`endif

// *** verif/rsf_encoder_properties.sv ***
// Port-level assertions for the RS-FEC encoder
`timescale 1ns/1ps
module rsf_encoder_properties (
    // Clock and reset
    input wire clk_sys,
    input wire rst_b,
    // Modes
    input wire master_mode,
    input wire data_mode,
    // Frame side
    input wire frame_valid,
    input wire frame_ready,
    // Pair side
    input wire pair_valid,
    input wire pair_ready,
    input wire [1:0] pair_bits
);
    reg [7:0] gap_r;
    reg took_r;
    reg mst_r;
    wire take = frame_valid && frame_ready;
    // Counts cycles without frame_ready since the last take
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gap_r <= 8'h00;
            took_r <= 1'b0;
            mst_r <= 1'b0;
        end else if (take) begin
            gap_r <= 8'h00;
            took_r <= 1'b1;
            mst_r <= master_mode;
        end else if (!frame_ready && gap_r != 8'hFF) begin
            gap_r <= gap_r + 8'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ready_drop_a: assert property (take |=> !frame_ready [*8])
        else $error("frame_ready held after take");
    ready_stand_a: assert property (frame_ready && !frame_valid |=> frame_ready)
        else $error("frame_ready dropped untaken");
    master_gap_a: assert property ($rose(frame_ready) && took_r && mst_r |-> gap_r >= 8'h7C)
        else $error("master frame too short");
    slave_gap_a: assert property ($rose(frame_ready) && took_r && !mst_r |-> gap_r >= 8'h7A)
        else $error("slave frame too short");
    pair_hold_a: assert property (pair_valid && !pair_ready |=> pair_valid && $stable(pair_bits))
        else $error("pair changed while stalled");
    train_valid_a: assert property (!data_mode |=> pair_valid)
        else $error("no training pair");
    data_idle_a: assert property (data_mode && !took_r && !pair_valid |=> !pair_valid)
        else $error("data pair without frame");
    reset_rel_a: assert property ($rose(rst_b) |-> ##[0:2] frame_ready)
        else $error("frame_ready late after reset");
    cover property (take && master_mode);
    cover property (take && !master_mode);
    cover property (pair_valid && !pair_ready && data_mode);
endmodule
bind rsf_encoder rsf_encoder_properties u_props (.clk_sys(clk_sys), .rst_b(rst_b),
    .master_mode(master_mode), .data_mode(data_mode), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .pair_valid(pair_valid), .pair_ready(pair_ready),
    .pair_bits(pair_bits));

// *** verif/rsf_mapper_model.sv ***
// Symbol mapper stand-in that takes bit pairs with random and long stalls
`timescale 1ns/1ps
module rsf_mapper_model #(
    parameter SEED = 1
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_b,
    // Pair handshake
    output reg pair_ready
);
    integer seed = SEED;
    reg [9:0] cyc_r;
    reg [31:0] rnd;
    // Long stalls let the symbol FIFO fill and refuse
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pair_ready <= 1'b0;
            cyc_r <= 10'h000;
        end else begin
            rnd <= $random(seed);
            cyc_r <= cyc_r + 10'h001;
            pair_ready <= (cyc_r[9:7] != 3'h0) & rnd[0];
        end
    end
endmodule

// *** verif/test_rsf_encoder.sv ***
// Self-checking bench for the RS-FEC encoder
`timescale 1ns/1ps
`include "rsf_regs.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_rsf_encoder;
    reg clk_sys = 1'b0;
    reg rst_b = 1'b0;
    reg master_mode = 1'b0;
    reg [1:0] speed_sel = 2'h0;
    reg data_mode = 1'b1;
    reg frame_valid = 1'b0;
    reg [`RSF_BLK_W-1:0] gbv = 0;
    reg [`RSF_MAINT_W-1:0] mb = 0;
    reg [1:0] training_bits = 2'h0;
    reg [1:0] tbg = 2'h0;
    wire frame_ready, pair_valid, pair_ready;
    wire [1:0] pair_bits;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 73153;
    int sub = 0;
    reg [7:0] q[$];
    reg [7:0] d, par[0:3][0:7];
    reg [32:0] sc = `RSF_SCR_SEED;
    reg b0, b1;
    // Generator rows: slave then master, low coefficient first
    reg [7:0] gen[0:1][0:8] = '{'{8'h18, 8'hC8, 8'hAD, 8'hEF, 8'h36, 8'h51, 8'h0B, 8'hFF, 8'h01},
        '{8'h26, 8'hE3, 8'h20, 8'hDA, 8'h01, 8'h3F, 8'h01, 8'h00, 8'h00}};
    rsf_encoder DUT (.clk_sys(clk_sys), .rst_b(rst_b), .master_mode(master_mode),
        .speed_sel(speed_sel), .data_mode(data_mode), .frame_valid(frame_valid),
        .frame_ready(frame_ready), .grouped_block_vector(gbv), .maintenance_bits(mb),
        .training_bits(training_bits), .pair_valid(pair_valid), .pair_ready(pair_ready),
        .pair_bits(pair_bits));
    rsf_mapper_model #(.SEED(73153)) u_map (.clk_sys(clk_sys), .rst_b(rst_b),
        .pair_ready(pair_ready));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic [7:0] gm(input [7:0] a, input [7:0] b);
        reg [7:0] r;
        r = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            r = {r[6:0], 1'b0} ^ (r[7] ? `RSF_PRIM_LOW : 8'h00);
            if (b[i]) r = r ^ a;
        end
        return r;
    endfunction
    task send_sf(input reg m, input reg [1:0] sp);
        int l, np, k, n, e;
        reg [991:0] v, x;
        reg [7:0] s, fb;
        l = m ? 1 : (sp == 2'h1 ? 2 : (sp == 2'h2 ? 4 : 1));
        np = m ? 6 : 8;
        k = m ? 124 : 122;
        n = 0;
        foreach (par[a, b]) par[a][b] = 8'h00;
        @(posedge clk_sys);
        master_mode <= m;
        speed_sel <= sp;
        for (int f = 0; f < l; f++) begin
            for (int i = 0; i < 31; i++) v[i*32 +: 32] = $random(seed);
            x = m ? v : {16'h0000, v[975:0]};
            for (int i = 0; i < k; i++) begin
                s = x[i*8 +: 8];
                q.push_back(s);
                e = n % l;
                fb = s ^ par[e][np-1];
                for (int r = np - 1; r > 0; r--) par[e][r] = par[e][r-1] ^ gm(gen[m][r], fb);
                par[e][0] = gm(gen[m][0], fb);
                n++;
            end
            gbv <= v[974:0];
            mb <= v[991:975];
            frame_valid <= 1'b1;
            do @(negedge clk_sys); while (!frame_ready);
            @(posedge clk_sys);
        end
        for (int r = np - 1; r >= 0; r--)
            for (int i = 0; i < l; i++) q.push_back(par[i][r]);
        frame_valid <= 1'b0;
        $display("superframe mode %0d speed %0d sent", m, sp);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Scrambler steps twice per accepted pair
    always @(posedge clk_sys) begin
        if (rst_b && pair_valid && pair_ready) begin
            b0 = sc[32] ^ sc[12];
            sc = {sc[31:0], b0};
            b1 = sc[32] ^ sc[12];
            sc = {sc[31:0], b1};
            if (q.size() > 0) begin
                d = q[0] >> (2 * sub);
                `CHK("data pair", {b1 ^ d[1], b0 ^ d[0]}, pair_bits)
                sub = (sub + 1) % 4;
                if (sub == 0) void'(q.pop_front());
            end else begin
                `CHK("train pair", {b1, b0} ^ tbg, pair_bits)
            end
        end
        if (!pair_valid || pair_ready) tbg = training_bits;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        send_sf(1'b1, 2'h0);
        send_sf(1'b1, 2'h0);
        for (int s = 0; s < 4; s++) send_sf(1'b0, s[1:0]);
        wait (q.size() == 0);
        repeat (4) @(posedge clk_sys);
        for (int t = 0; t < 4; t++) begin
            data_mode <= 1'b0;
            training_bits <= t[1:0];
            repeat (40) @(posedge clk_sys);
        end
        $display("training done");
        end_sim;
    end
    initial begin
        #300000;
        mismatches++;
        $display("[FAIL] watchdog expired");
        end_sim;
    end
endmodule
